// File: core/ipf_map.vh
// register map, field layout and reset values of the priority block
`ifndef IPF_MAP_VH
`define IPF_MAP_VH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define IPF_ADDR_W          4
`define IPF_DATA_W          16
`define IPF_ZERO16          16'h0000

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define IPF_OFF_TIMER_OC_IC 4'h0
`define IPF_OFF_WAKEUP      4'h1

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define IPF_PRIO_W          3
`define IPF_TIMER_HI        14
`define IPF_TIMER_LO        12
`define IPF_COMPARE_HI      10
`define IPF_COMPARE_LO      8
`define IPF_CAPTURE_HI      6
`define IPF_CAPTURE_LO      4
`define IPF_WAKE_HI         2
`define IPF_WAKE_LO         0

// ----------------------------------------------------------------------
// field values
// ----------------------------------------------------------------------
`define IPF_PRIO_RESET      3'h4
`define IPF_PRIO_OFF        3'h0
`define IPF_PRIO_MAX        3'h7

// ----------------------------------------------------------------------
// sources
// ----------------------------------------------------------------------
`define IPF_NSRC            4
`define IPF_SRC_W           2
`define IPF_SRC_TIMER       2'h0
`define IPF_SRC_COMPARE     2'h1
`define IPF_SRC_CAPTURE     2'h2
`define IPF_SRC_WAKE        2'h3

`endif

// File: core/ipf_prio_gate.v
// per-source gate: qualifies a flag by its priority field
`include "ipf_map.vh"

module ipf_prio_gate (
    input  wire                   clk,
    input  wire                   sys_rst,
    input  wire                   flag,
    input  wire [`IPF_PRIO_W-1:0] prio,
    output reg                    req_r,
    output reg  [`IPF_PRIO_W-1:0] level_r
);

    // ------------------------------------------------------------------
    // gating
    // ------------------------------------------------------------------
    wire                   enabled;
    wire                   req_nxt;
    wire [`IPF_PRIO_W-1:0] level_nxt;

    // RQ5: zero disables source
    assign enabled   = (prio != `IPF_PRIO_OFF);
    assign req_nxt   = flag & enabled;
    // RQ3: direct level map
    // RQ4: value is the level
    assign level_nxt = req_nxt ? prio : `IPF_PRIO_OFF;

    always @(posedge clk) begin
        if (sys_rst) begin
            req_r   <= 1'b0;
            level_r <= `IPF_PRIO_OFF;
        end else begin
            req_r   <= req_nxt;
            level_r <= level_nxt;
        end
    end

endmodule

// File: core/ipf_top.v
// priority field registers with per-source gating and arbitration
//
// The plain strobed port and the address map are this design's own decisions.
`include "ipf_map.vh"

// Summary of operation
// RQ1: a 16-bit register holds 3-bit timer, compare and capture priorities.
// RQ2: the timer priority sits in bits 14 to 12 and is read and written.
// RQ3: a field value of 111 gives the source level 7, the highest.
// RQ4: other nonzero values map straight to levels, 001 being level 1.
// RQ5: a field value of 000 disables the source so it never requests.
// RQ6: a second 16-bit register holds only the wake priority in bits 2-0.
// RQ7: unimplemented bits read as zero and ignore writes.
// RQ8: the wake field uses the same seven-level coding, zero disabling it.
// RQ9: reset loads every implemented field with 100, level 4.
module ipf_top (
    input  wire                   clk,
    input  wire                   sys_rst,
    input  wire [`IPF_ADDR_W-1:0] reg_addr,
    input  wire [`IPF_DATA_W-1:0] reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [`IPF_DATA_W-1:0] reg_rdata,
    input  wire                   timer_two_flag,
    input  wire                   compare_two_flag,
    input  wire                   capture_two_flag,
    input  wire                   low_power_wake_flag,
    output wire [`IPF_NSRC-1:0]   src_req,
    output reg                    irq_pending_r,
    output reg  [`IPF_PRIO_W-1:0] irq_level_r,
    output reg  [`IPF_SRC_W-1:0]  irq_source_r
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire sel_timer_oc_ic;
    wire sel_wakeup;
    wire wr_timer_oc_ic;
    wire wr_wakeup;

    assign sel_timer_oc_ic = (reg_addr == `IPF_OFF_TIMER_OC_IC);
    assign sel_wakeup      = (reg_addr == `IPF_OFF_WAKEUP);
    // an unmapped index selects nothing, so its writes are dropped
    assign wr_timer_oc_ic  = reg_wr & sel_timer_oc_ic;
    assign wr_wakeup       = reg_wr & sel_wakeup;

    // ------------------------------------------------------------------
    // priority fields
    // ------------------------------------------------------------------
    reg  [`IPF_PRIO_W-1:0] timer_two_priority_r;
    reg  [`IPF_PRIO_W-1:0] compare_two_priority_r;
    reg  [`IPF_PRIO_W-1:0] capture_two_priority_r;
    reg  [`IPF_PRIO_W-1:0] low_power_wake_priority_r;

    reg  [`IPF_PRIO_W-1:0] timer_two_priority_nxt;
    reg  [`IPF_PRIO_W-1:0] compare_two_priority_nxt;
    reg  [`IPF_PRIO_W-1:0] capture_two_priority_nxt;
    reg  [`IPF_PRIO_W-1:0] low_power_wake_priority_nxt;

    // only field bits are stored, so stray write bits simply vanish
    always @* begin
        // hold by default; a write replaces whole fields at once
        timer_two_priority_nxt      = timer_two_priority_r;
        compare_two_priority_nxt    = compare_two_priority_r;
        capture_two_priority_nxt    = capture_two_priority_r;
        low_power_wake_priority_nxt = low_power_wake_priority_r;
        if (wr_timer_oc_ic) begin
            // RQ1: three fields written
            // RQ2: timer field bits 14-12
            timer_two_priority_nxt =
                reg_wdata[`IPF_TIMER_HI:`IPF_TIMER_LO];
            compare_two_priority_nxt =
                reg_wdata[`IPF_COMPARE_HI:`IPF_COMPARE_LO];
            capture_two_priority_nxt =
                reg_wdata[`IPF_CAPTURE_HI:`IPF_CAPTURE_LO];
        end
        if (wr_wakeup) begin
            // RQ6: wake field bits 2-0
            low_power_wake_priority_nxt =
                reg_wdata[`IPF_WAKE_HI:`IPF_WAKE_LO];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            // RQ9: level 4 at reset
            timer_two_priority_r      <= `IPF_PRIO_RESET;
            compare_two_priority_r    <= `IPF_PRIO_RESET;
            capture_two_priority_r    <= `IPF_PRIO_RESET;
            low_power_wake_priority_r <= `IPF_PRIO_RESET;
        end else begin
            timer_two_priority_r      <= timer_two_priority_nxt;
            compare_two_priority_r    <= compare_two_priority_nxt;
            capture_two_priority_r    <= capture_two_priority_nxt;
            low_power_wake_priority_r <= low_power_wake_priority_nxt;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // read mux; the registered copy below is what the bus sees
    reg [`IPF_DATA_W-1:0] rd_word;

    always @* begin
        // an unmapped index matches no branch and reads as zero
        rd_word = `IPF_ZERO16;
        if (sel_timer_oc_ic) begin
            // RQ7: gaps stay zero
            rd_word[`IPF_TIMER_HI:`IPF_TIMER_LO] =
                timer_two_priority_r;
            rd_word[`IPF_COMPARE_HI:`IPF_COMPARE_LO] =
                compare_two_priority_r;
            rd_word[`IPF_CAPTURE_HI:`IPF_CAPTURE_LO] =
                capture_two_priority_r;
        end else if (sel_wakeup) begin
            // RQ7: upper bits zero
            rd_word[`IPF_WAKE_HI:`IPF_WAKE_LO] =
                low_power_wake_priority_r;
        end
    end

    // ------------------------------------------------------------------
    // read data register
    // ------------------------------------------------------------------
    reg [`IPF_DATA_W-1:0] rdata_nxt;

    // data holds only in the cycle after the read, zero otherwise,
    // so a bus that ORs several slaves needs no extra gating
    always @* begin
        if (reg_rd) begin
            rdata_nxt = rd_word;
        end else begin
            rdata_nxt = `IPF_ZERO16;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= `IPF_ZERO16;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // per-source gating
    // ------------------------------------------------------------------
    wire [`IPF_NSRC-1:0]             flag_vec;
    wire [`IPF_NSRC*`IPF_PRIO_W-1:0] prio_vec;
    wire [`IPF_NSRC*`IPF_PRIO_W-1:0] level_vec;

    // flags come from logic on this clock, so no synchroniser stage
    assign flag_vec = {low_power_wake_flag,
                       capture_two_flag,
                       compare_two_flag,
                       timer_two_flag};

    // RQ8: wake uses same coding
    assign prio_vec = {low_power_wake_priority_r,
                       capture_two_priority_r,
                       compare_two_priority_r,
                       timer_two_priority_r};

    // one gate per source; bit order matches src_req
    genvar gi;
    generate
        for (gi = 0; gi < `IPF_NSRC; gi = gi + 1) begin : g_src
            ipf_prio_gate u_gate (
                .clk     (clk),
                .sys_rst (sys_rst),
                .flag    (flag_vec[gi]),
                .prio    (prio_vec[gi*`IPF_PRIO_W +: `IPF_PRIO_W]),
                .req_r   (src_req[gi]),
                .level_r (level_vec[gi*`IPF_PRIO_W +: `IPF_PRIO_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------------
    reg [`IPF_PRIO_W-1:0] best_level;
    reg [`IPF_SRC_W-1:0]  best_src;
    reg                   best_any;
    reg [`IPF_PRIO_W-1:0] cand;
    integer               si;

    // strict greater-than: on a tie the lower source index wins,
    // so the timer beats the wake source at equal level
    always @* begin
        best_level = `IPF_PRIO_OFF;
        best_src   = `IPF_SRC_TIMER;
        best_any   = 1'b0;
        cand       = `IPF_PRIO_OFF;
        for (si = 0; si < `IPF_NSRC; si = si + 1) begin
            cand = level_vec[si*`IPF_PRIO_W +: `IPF_PRIO_W];
            // RQ3: higher level wins
            if (src_req[si] && (cand > best_level)) begin
                best_level = cand;
                best_src   = si[`IPF_SRC_W-1:0];
                best_any   = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // arbitration register
    // ------------------------------------------------------------------
    // one stage keeps decode glitches off the request outputs
    always @(posedge clk) begin
        if (sys_rst) begin
            irq_pending_r <= 1'b0;
            irq_level_r   <= `IPF_PRIO_OFF;
            irq_source_r  <= `IPF_SRC_TIMER;
        end else begin
            irq_pending_r <= best_any;
            irq_level_r   <= best_level;
            irq_source_r  <= best_src;
        end
    end

endmodule

// File: verification/ipf_top_properties.sv
// port assertions for the priority field block
`include "ipf_map.vh"
module ipf_top_chk (
    input wire                   clk,
    input wire                   sys_rst,
    input wire [`IPF_ADDR_W-1:0] reg_addr,
    input wire [`IPF_DATA_W-1:0] reg_wdata,
    input wire                   reg_wr,
    input wire                   reg_rd,
    input wire [`IPF_DATA_W-1:0] reg_rdata,
    input wire                   timer_two_flag,
    input wire                   compare_two_flag,
    input wire                   capture_two_flag,
    input wire                   low_power_wake_flag,
    input wire [`IPF_NSRC-1:0]   src_req,
    input wire                   irq_pending_r,
    input wire [`IPF_PRIO_W-1:0] irq_level_r,
    input wire [`IPF_SRC_W-1:0]  irq_source_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [3:0] flags = {low_power_wake_flag, capture_two_flag,
                        compare_two_flag, timer_two_flag};
    chk_rdata_quiet: assert property (
        !reg_rd |=> reg_rdata == 16'h0000) else $error("stray read data");
    chk_rdata_mask: assert property (reg_rd |=>
        (reg_rdata & ($past(reg_addr) == `IPF_OFF_TIMER_OC_IC ?
        16'h888F : 16'hFFF8)) == 16'h0000) else $error("reserved bit set");
    chk_src_gate: assert property (
        1'b1 |=> (src_req & ~$past(flags)) == 4'h0)
        else $error("request without flag");
    chk_pend_any: assert property (
        1'b1 |=> irq_pending_r == (|$past(src_req)))
        else $error("pending does not follow requests");
    chk_idle_zero: assert property (
        !irq_pending_r |-> irq_level_r == 3'h0 && irq_source_r == 2'h0)
        else $error("level shown while idle");
    chk_level_live: assert property (irq_pending_r |->
        irq_level_r != 3'h0 && (($past(src_req) >> irq_source_r) & 4'h1))
        else $error("winner not requesting");
    chk_timer_back: assert property (
        reg_wr && reg_addr == `IPF_OFF_TIMER_OC_IC ##1
        reg_rd && reg_addr == `IPF_OFF_TIMER_OC_IC |=>
        reg_rdata == ($past(reg_wdata, 2) & 16'h7770))
        else $error("first register readback wrong");
    chk_wake_back: assert property (
        reg_wr && reg_addr == `IPF_OFF_WAKEUP ##1
        reg_rd && reg_addr == `IPF_OFF_WAKEUP |=>
        reg_rdata == ($past(reg_wdata, 2) & 16'h0007))
        else $error("wake register readback wrong");
endmodule
bind ipf_top ipf_top_chk i_ipf_top_chk (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_two_flag(timer_two_flag),
    .compare_two_flag(compare_two_flag), .capture_two_flag(capture_two_flag),
    .low_power_wake_flag(low_power_wake_flag), .src_req(src_req),
    .irq_pending_r(irq_pending_r), .irq_level_r(irq_level_r),
    .irq_source_r(irq_source_r));

// File: verification/tb.sv
// self-checking bench for the priority field block
`include "ipf_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    reg         clk;
    reg         sys_rst;
    reg  [3:0]  reg_addr;
    reg  [15:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    reg  [3:0]  fl;
    wire [15:0] reg_rdata;
    wire [3:0]  src_req;
    wire        irq_pending_r;
    wire [2:0]  irq_level_r;
    wire [1:0]  irq_source_r;
    reg  [2:0]  f [0:3];
    reg  [2:0]  lv;
    reg  [1:0]  sr;
    reg  [15:0] d;
    reg  [3:0]  a;
    integer     error_cnt;
    integer     tests_run;
    integer     i;
    integer     k;
    ipf_top i_ipf_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer_two_flag(fl[0]),
        .compare_two_flag(fl[1]), .capture_two_flag(fl[2]),
        .low_power_wake_flag(fl[3]), .src_req(src_req),
        .irq_pending_r(irq_pending_r), .irq_level_r(irq_level_r),
        .irq_source_r(irq_source_r));
    // expected register image from the bench copy of the fields
    function [15:0] img(input [3:0] x);
        img = x == `IPF_OFF_TIMER_OC_IC ?
            {1'b0, f[0], 1'b0, f[1], 1'b0, f[2], 4'h0} :
            x == `IPF_OFF_WAKEUP ? {13'h0000, f[3]} : 16'h0000;
    endfunction
    // expected requests: a flag counts only under a nonzero field
    function [3:0] req_exp(input [3:0] fv);
        integer j;
        req_exp = 4'h0;
        for (j = 0; j < 4; j = j + 1)
            req_exp[j] = fv[j] && f[j] != `IPF_PRIO_OFF;
    endfunction
    task check(input string n, input [15:0] s, input [15:0] e);
        tests_run = tests_run + 1;
        if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %s exp %h seen %h", n, e, s);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // read clears the write strobe too, so a write may precede it directly
    task rd(input [3:0] x);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= x;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("read data", reg_rdata, img(x));
    endtask
    task wr(input [3:0] x, input [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= x;
        reg_wdata <= v;
        if (x == `IPF_OFF_TIMER_OC_IC) begin
            f[0] = v[14:12];
            f[1] = v[10:8];
            f[2] = v[6:4];
        end
        if (x == `IPF_OFF_WAKEUP)
            f[3] = v[2:0];
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // generous bound: the sequence needs well under 1000 cycles
    initial begin
        #20000;
        error_cnt = error_cnt + 1;
        stop_test;
    end
    initial begin
        error_cnt = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fl = 4'h0;
        for (k = 0; k < 4; k = k + 1)
            f[k] = `IPF_PRIO_RESET;
        d = $urandom(76);
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`IPF_OFF_TIMER_OC_IC);
        rd(`IPF_OFF_WAKEUP);
        for (i = 0; i < 24; i = i + 1) begin
            a = $urandom_range(2, 0);
            d = $urandom;
            wr(a, d);
            rd(a);
        end
        // first eight passes sweep every timer level with only its flag up
        for (i = 0; i < 16; i = i + 1) begin
            d = $urandom;
            if (i < 8)
                d[14:12] = i[2:0];
            wr(`IPF_OFF_TIMER_OC_IC, d);
            wr(`IPF_OFF_WAKEUP, {d[7:0], d[15:8]});
            @(posedge clk);
            reg_wr <= 1'b0;
            fl <= i < 8 ? 4'h1 : d[3:0];
            repeat (3) @(posedge clk);
            #1;
            lv = 3'h0;
            sr = 2'h0;
            for (k = 0; k < 4; k = k + 1)
                if (fl[k] && f[k] > lv) begin
                    lv = f[k];
                    sr = k[1:0];
                end
            check("request", src_req, req_exp(fl));
            check("pending", irq_pending_r, lv != 3'h0);
            check("level", irq_level_r, lv);
            check("source", irq_source_r, sr);
        end
        stop_test;
    end
endmodule
